/* rtl/edoc_regs.svh */
// constants for the extended-output page dram controller
// Summary of operation
// R1 - every read meets the read hold from column or from row strobe.
// R2 - the memory floats its data pins an output turn-off delay after both strobes rise.
// R3 - write enable low before column strobe falls gives an early write, outputs stay open.
// R4 - late write enable meeting all delay minimums gives read-modify-write with read data out.
// R5 - the controller meets early-write or read-modify-write conditions, never something between; its late-write op meets neither.
// R6 - output enable high and write enable falling after column strobe gives a late write.
// R7 - write data is timed from column strobe fall, or from write enable fall when late.
// R8 - with output enable tied low, no late write or read-modify-write is attempted.
// R9 - a hidden refresh after a write holds write enable low and output enable high.
// R10 - write enable low around row strobe fall in column-before-row refresh enters test mode.
// R11 - after self refresh, refresh every row before normal use.
// R12 - write enable is held high around row strobe fall in normal accesses.
// R13 - column strobe low before row strobe and a long row pulse enter self refresh.
// R14 - row and column addresses share the address pins in one of two splits.
// R15 - the array holds 16,777,216 four-bit words in one of two shapes.
// R16 - the row address is taken at row strobe fall, then the column at column strobe fall.
// R17 - 4,096 column-before-row refreshes are spread over every 64ms.
// R18 - write enable low means write, otherwise read.
// R19 - read data is driven only while output enable is low.
// R20 - read data stays valid after column strobe rises while row strobe and output enable stay low.
// R21 - toggling output enable with both strobes low switches the data pins on and off.
// R22 - output enable high at column strobe rise keeps the data pins off until the next fall.
// R23 - an output enable pulse during column strobe high turns the data pins off.
// R24 - page mode keeps row strobe low and cycles column strobe with new column addresses.
`ifndef EDOC_REGS_SVH
`define EDOC_REGS_SVH

`define EDOC_ADDR_W       24
`define EDOC_PIN_W        13
`define EDOC_DQ_W         4
`define EDOC_CNT_W        16
`define EDOC_REFI_W       11
`define EDOC_BURST_W      13
`define EDOC_BUF_DEPTH    2
// row/column split of the word address
`define EDOC_COL_NARROW   11
`define EDOC_COL_SQUARE   12

`define EDOC_CLK_NS       10
`define EDOC_CYC_MIN(ns)  ((((ns) + `EDOC_CLK_NS - 1) / `EDOC_CLK_NS))
`define EDOC_CYC_MAX(ns)  (((ns) / `EDOC_CLK_NS))

`define EDOC_T_RAH_NS     10
`define EDOC_T_RCD_NS     14
`define EDOC_T_RAC_NS     60
`define EDOC_T_CWL_NS     15
`define EDOC_T_OD_NS      15
`define EDOC_T_CP_NS      10
`define EDOC_T_RAS_NS     60
`define EDOC_T_RP_NS      40
`define EDOC_T_CSR_NS     5
`define EDOC_T_RPS_NS     110
`define EDOC_T_RASS_NS    100000
`define EDOC_T_RASP_NS    125000
`define EDOC_T_REF_NS     64000000
`define EDOC_REF_CYCLES   4096

`define EDOC_C_RAH        `EDOC_CYC_MIN(`EDOC_T_RAH_NS)
`define EDOC_C_RCD        `EDOC_CYC_MIN(`EDOC_T_RCD_NS)
`define EDOC_C_COL_RD     (`EDOC_CYC_MIN(`EDOC_T_RAC_NS) - `EDOC_C_RCD)
`define EDOC_C_CWL        `EDOC_CYC_MIN(`EDOC_T_CWL_NS)
`define EDOC_C_OD         `EDOC_CYC_MIN(`EDOC_T_OD_NS)
`define EDOC_C_CP         `EDOC_CYC_MIN(`EDOC_T_CP_NS)
`define EDOC_C_RAS        `EDOC_CYC_MIN(`EDOC_T_RAS_NS)
`define EDOC_C_RP         `EDOC_CYC_MIN(`EDOC_T_RP_NS)
`define EDOC_C_CSR        `EDOC_CYC_MIN(`EDOC_T_CSR_NS)
`define EDOC_C_RPS        `EDOC_CYC_MIN(`EDOC_T_RPS_NS)
`define EDOC_C_REFI       `EDOC_CYC_MAX(`EDOC_T_REF_NS / `EDOC_REF_CYCLES)
// cycles kept in hand before the longest page time runs out
`define EDOC_C_PAGE_GUARD 16

`endif

/* rtl/edoc_pkg.sv */
// types shared by the dram controller files
`include "edoc_regs.svh"
package edoc_pkg;

    typedef enum logic [2:0] {
        EDOC_OP_READ  = 3'h0,
        EDOC_OP_EARLY = 3'h1,
        EDOC_OP_LATE  = 3'h2,
        EDOC_OP_RMW   = 3'h3,
        EDOC_OP_TEST  = 3'h4
    } edoc_op_e;

    typedef struct packed {
        edoc_op_e                 op;
        logic [`EDOC_ADDR_W-1:0]  addr;
        logic [`EDOC_DQ_W-1:0]    wdata;
    } edoc_req_s;

    typedef struct packed {
        logic                     ras_n;
        logic                     cas_n;
        logic                     we_n;
        logic                     oe_n;
        logic [`EDOC_PIN_W-1:0]   addr;
        logic [`EDOC_DQ_W-1:0]    dq_out;
        logic                     dq_oe;
    } edoc_pins_s;

    typedef enum logic [11:0] {
        EDOC_S_IDLE  = 12'h001,
        EDOC_S_ROW   = 12'h002,
        EDOC_S_ADDR  = 12'h004,
        EDOC_S_COL   = 12'h008,
        EDOC_S_TURN  = 12'h010,
        EDOC_S_LATE  = 12'h020,
        EDOC_S_CASUP = 12'h040,
        EDOC_S_PRE   = 12'h080,
        EDOC_S_RCAS  = 12'h100,
        EDOC_S_RRAS  = 12'h200,
        EDOC_S_SELF  = 12'h400,
        EDOC_S_SEXIT = 12'h800
    } edoc_state_e;

endpackage : edoc_pkg

/* rtl/edoc_buf.sv */
// small valid/ready buffer for read words
`timescale 1ns/1ps
module edoc_buf #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 2
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [DEPTH-1:0] vld_q;
    logic [DEPTH-1:0] vld_d;
    logic             placed;

    // entry 0 is always the head, so the outputs come straight from flops
    always_comb begin
        mem_d  = mem_q;
        vld_d  = vld_q;
        placed = 1'b0;
        if (vld_q[0] && out_ready) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                mem_d[i] = mem_q[i+1];
                vld_d[i] = vld_q[i+1];
            end
            vld_d[DEPTH-1] = 1'b0;
        end
        // ready is taken from the full flag, not from a same-cycle pop
        if (in_valid && !vld_q[DEPTH-1]) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (!vld_d[i] && !placed) begin
                    mem_d[i] = in_data;
                    vld_d[i] = 1'b1;
                    placed   = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            vld_q <= '0;
        end else begin
            mem_q <= mem_d;
            vld_q <= vld_d;
        end
    end

    assign in_ready  = !vld_q[DEPTH-1];
    assign out_valid = vld_q[0];
    assign out_data  = mem_q[0];

endmodule : edoc_buf

/* rtl/edoc_ctrl.sv */
// host controller for an extended-output page dram
`timescale 1ns/1ps
`include "edoc_regs.svh"
module edoc_ctrl #(
    parameter int SELF_MIN_CYC = `EDOC_CYC_MIN(`EDOC_T_RASS_NS),
    parameter int PAGE_MAX_CYC = `EDOC_CYC_MAX(`EDOC_T_RASP_NS)
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire logic                   cfg_square,
    input  wire logic                   self_req,
    output logic                        self_active,
    input  wire logic                   req_valid,
    output logic                        req_ready,
    input  wire edoc_pkg::edoc_req_s    req,
    output logic                        rd_valid,
    input  wire logic                   rd_ready,
    output logic [`EDOC_DQ_W-1:0]       rd_data,
    output edoc_pkg::edoc_pins_s        pins,
    input  wire logic [`EDOC_DQ_W-1:0]  dq_in
);
    edoc_pkg::edoc_state_e      state_q;
    edoc_pkg::edoc_state_e      state_d;
    logic [`EDOC_CNT_W-1:0]     cnt_q;
    logic [`EDOC_CNT_W-1:0]     cnt_d;
    logic [`EDOC_CNT_W-1:0]     ras_cnt_q;
    logic [`EDOC_CNT_W-1:0]     ras_cnt_d;
    edoc_pkg::edoc_req_s        act_q;
    edoc_pkg::edoc_req_s        act_d;
    edoc_pkg::edoc_req_s        cur_q;
    edoc_pkg::edoc_req_s        cur_d;
    logic                       cur_vld_q;
    logic                       cur_vld_d;
    logic                       self_q;
    logic                       self_d;
    logic                       tst_q;
    logic                       tst_d;
    logic [`EDOC_BURST_W:0]     burst_q;
    logic [`EDOC_BURST_W:0]     burst_d;
    logic [`EDOC_REFI_W-1:0]    refi_q;
    logic [`EDOC_REFI_W-1:0]    refi_d;
    logic                       pend_q;
    logic                       pend_d;
    logic                       ref_take;
    logic                       done;
    logic                       ras_low;
    edoc_pkg::edoc_pins_s       pins_q;
    edoc_pkg::edoc_pins_s       pins_d;
    logic                       buf_push;
    logic                       buf_ready;

    // wait length n cycles, counter reaches zero on the last one
    function automatic logic [`EDOC_CNT_W-1:0] ld(input int n);
        ld = (n > 1) ? `EDOC_CNT_W'(n - 1) : '0;
    endfunction : ld

    function automatic logic reads(input edoc_pkg::edoc_op_e op);
        reads = (op == edoc_pkg::EDOC_OP_READ) || (op == edoc_pkg::EDOC_OP_RMW);
    endfunction : reads

    // R14 address split
    function automatic logic [`EDOC_PIN_W-1:0] row_of(input logic [`EDOC_ADDR_W-1:0] a,
                                                     input logic sq);
        row_of = sq ? `EDOC_PIN_W'(a[`EDOC_ADDR_W-1:`EDOC_COL_SQUARE])
                    : `EDOC_PIN_W'(a[`EDOC_ADDR_W-1:`EDOC_COL_NARROW]);
    endfunction : row_of

    // R15 column part of the 24-bit word address
    function automatic logic [`EDOC_PIN_W-1:0] col_of(input logic [`EDOC_ADDR_W-1:0] a,
                                                     input logic sq);
        col_of = sq ? `EDOC_PIN_W'(a[`EDOC_COL_SQUARE-1:0])
                    : `EDOC_PIN_W'(a[`EDOC_COL_NARROW-1:0]);
    endfunction : col_of

    function automatic logic [`EDOC_CNT_W-1:0] col_len(input edoc_pkg::edoc_op_e op);
        unique case (op)
            edoc_pkg::EDOC_OP_EARLY: col_len = ld(`EDOC_C_CWL);
            edoc_pkg::EDOC_OP_LATE:  col_len = ld(1);
            default:                 col_len = ld(`EDOC_C_COL_RD);
        endcase
    endfunction : col_len

    assign done = (cnt_q == '0);

    always_comb begin
        state_d   = state_q;
        cnt_d     = done ? cnt_q : cnt_q - 1'b1;
        act_d     = act_q;
        cur_d     = cur_q;
        cur_vld_d = cur_vld_q;
        self_d    = self_q;
        tst_d     = tst_q;
        burst_d   = burst_q;
        ref_take  = 1'b0;
        if (req_valid && req_ready) begin
            cur_d     = req;
            cur_vld_d = 1'b1;
        end
        unique case (state_q)
            edoc_pkg::EDOC_S_IDLE: begin
                if (self_req) begin
                    // R13 column strobe first, row strobe then held low
                    state_d = edoc_pkg::EDOC_S_RCAS;
                    cnt_d   = ld(`EDOC_C_CSR);
                    self_d  = 1'b1;
                    tst_d   = 1'b0;
                end else if (pend_q || burst_q != '0) begin
                    // R9 refresh only from precharge, never hidden
                    state_d  = edoc_pkg::EDOC_S_RCAS;
                    cnt_d    = ld(`EDOC_C_CSR);
                    tst_d    = 1'b0;
                    ref_take = pend_q;
                end else if (cur_vld_q && cur_q.op == edoc_pkg::EDOC_OP_TEST) begin
                    // R10 test-mode refresh on request
                    state_d   = edoc_pkg::EDOC_S_RCAS;
                    cnt_d     = ld(`EDOC_C_CSR);
                    tst_d     = 1'b1;
                    cur_vld_d = 1'b0;
                end else if (cur_vld_q && (!reads(cur_q.op) || buf_ready)) begin
                    state_d   = edoc_pkg::EDOC_S_ROW;
                    cnt_d     = ld(`EDOC_C_RAH);
                    act_d     = cur_q;
                    cur_vld_d = 1'b0;
                end
            end
            edoc_pkg::EDOC_S_ROW: begin
                if (done) begin
                    state_d = edoc_pkg::EDOC_S_ADDR;
                    cnt_d   = ld(`EDOC_C_RCD - `EDOC_C_RAH);
                end
            end
            edoc_pkg::EDOC_S_ADDR: begin
                if (done) begin
                    state_d = edoc_pkg::EDOC_S_COL;
                    cnt_d   = col_len(act_q.op);
                end
            end
            edoc_pkg::EDOC_S_COL: begin
                if (done) begin
                    if (reads(act_q.op)) begin
                        // R2 release the bus before the data pins turn round
                        state_d = edoc_pkg::EDOC_S_TURN;
                        cnt_d   = ld(`EDOC_C_OD);
                    end else if (act_q.op == edoc_pkg::EDOC_OP_LATE) begin
                        state_d = edoc_pkg::EDOC_S_LATE;
                        cnt_d   = ld(`EDOC_C_CWL + 1);
                    end else begin
                        state_d = edoc_pkg::EDOC_S_CASUP;
                        cnt_d   = ld(`EDOC_C_CP);
                    end
                end
            end
            edoc_pkg::EDOC_S_TURN: begin
                if (done) begin
                    // R4 write phase follows the read phase
                    if (act_q.op == edoc_pkg::EDOC_OP_RMW) begin
                        state_d = edoc_pkg::EDOC_S_LATE;
                        cnt_d   = ld(`EDOC_C_CWL + 1);
                    end else begin
                        state_d = edoc_pkg::EDOC_S_CASUP;
                        cnt_d   = ld(`EDOC_C_CP);
                    end
                end
            end
            edoc_pkg::EDOC_S_LATE: begin
                if (done) begin
                    state_d = edoc_pkg::EDOC_S_CASUP;
                    cnt_d   = ld(`EDOC_C_CP);
                end
            end
            edoc_pkg::EDOC_S_CASUP: begin
                if (done) begin
                    // R24 stay in the open row for a same-row request
                    if (cur_vld_q && cur_q.op != edoc_pkg::EDOC_OP_TEST && !pend_q &&
                        !self_req && (!reads(cur_q.op) || buf_ready) &&
                        row_of(cur_q.addr, cfg_square) == row_of(act_q.addr, cfg_square) &&
                        ras_cnt_q < `EDOC_CNT_W'(PAGE_MAX_CYC - `EDOC_C_PAGE_GUARD)) begin
                        state_d   = edoc_pkg::EDOC_S_ADDR;
                        cnt_d     = ld(1);
                        act_d     = cur_q;
                        cur_vld_d = 1'b0;
                    end else if (ras_cnt_q >= `EDOC_CNT_W'(`EDOC_C_RAS)) begin
                        state_d = edoc_pkg::EDOC_S_PRE;
                        cnt_d   = ld(`EDOC_C_RP);
                    end
                end
            end
            edoc_pkg::EDOC_S_PRE: begin
                if (done) begin
                    state_d = edoc_pkg::EDOC_S_IDLE;
                    tst_d   = 1'b0;
                end
            end
            edoc_pkg::EDOC_S_RCAS: begin
                if (done) begin
                    state_d = edoc_pkg::EDOC_S_RRAS;
                    cnt_d   = ld(`EDOC_C_RAS);
                end
            end
            edoc_pkg::EDOC_S_RRAS: begin
                if (done) begin
                    if (self_q) begin
                        state_d = edoc_pkg::EDOC_S_SELF;
                    end else begin
                        state_d = edoc_pkg::EDOC_S_PRE;
                        cnt_d   = ld(`EDOC_C_RP);
                        if (!tst_q && burst_q != '0) begin
                            burst_d = burst_q - 1'b1;
                        end
                    end
                end
            end
            edoc_pkg::EDOC_S_SELF: begin
                // R13 row strobe held past the least self-refresh pulse
                if (!self_req && ras_cnt_q >= `EDOC_CNT_W'(SELF_MIN_CYC)) begin
                    state_d = edoc_pkg::EDOC_S_SEXIT;
                    cnt_d   = ld(`EDOC_C_RPS);
                    self_d  = 1'b0;
                end
            end
            edoc_pkg::EDOC_S_SEXIT: begin
                if (done) begin
                    // R11 full burst of refreshes before any access
                    state_d = edoc_pkg::EDOC_S_IDLE;
                    burst_d = (`EDOC_BURST_W+1)'(`EDOC_REF_CYCLES);
                end
            end
            default: begin
                state_d = edoc_pkg::EDOC_S_IDLE;
            end
        endcase
    end

    // R17 one refresh due every interval, the set beats the clear
    always_comb begin
        refi_d = (refi_q == `EDOC_REFI_W'(`EDOC_C_REFI - 1)) ? '0 : refi_q + 1'b1;
        pend_d = (refi_q == `EDOC_REFI_W'(`EDOC_C_REFI - 1)) || (pend_q && !ref_take);
    end

    always_comb begin
        ras_low = (state_d != edoc_pkg::EDOC_S_IDLE) && (state_d != edoc_pkg::EDOC_S_PRE) &&
                  (state_d != edoc_pkg::EDOC_S_RCAS) && (state_d != edoc_pkg::EDOC_S_SEXIT);
        if (!ras_low) begin
            ras_cnt_d = '0;
        end else if (ras_cnt_q == '1) begin
            ras_cnt_d = ras_cnt_q;
        end else begin
            ras_cnt_d = ras_cnt_q + 1'b1;
        end
    end

    // pin values follow the next state so every pin leaves a flop
    always_comb begin
        pins_d        = '0;
        pins_d.ras_n  = !ras_low;
        pins_d.cas_n  = 1'b1;
        // R1 R12 write enable high unless a write phase or test-mode entry pulls it low
        pins_d.we_n   = 1'b1;
        pins_d.oe_n   = 1'b1;
        pins_d.dq_out = act_d.wdata;
        unique case (state_d)
            edoc_pkg::EDOC_S_ROW: begin
                // R16 row address first
                pins_d.addr = row_of(act_d.addr, cfg_square);
            end
            edoc_pkg::EDOC_S_ADDR: begin
                pins_d.addr = col_of(act_d.addr, cfg_square);
                // R3 R7 early write: data and write enable ahead of column strobe
                if (act_d.op == edoc_pkg::EDOC_OP_EARLY) begin
                    pins_d.we_n  = 1'b0;
                    pins_d.dq_oe = 1'b1;
                end
            end
            edoc_pkg::EDOC_S_COL: begin
                // R16 column taken at column strobe fall
                pins_d.addr  = col_of(act_d.addr, cfg_square);
                pins_d.cas_n = 1'b0;
                // R18 R19 reads drop output enable, writes hold it high
                pins_d.oe_n  = !reads(act_d.op);
                pins_d.we_n  = (act_d.op != edoc_pkg::EDOC_OP_EARLY);
                pins_d.dq_oe = !reads(act_d.op);
            end
            edoc_pkg::EDOC_S_TURN: begin
                // R22 R8 output enable high before column strobe rises
                pins_d.addr  = col_of(act_d.addr, cfg_square);
                pins_d.cas_n = 1'b0;
            end
            edoc_pkg::EDOC_S_LATE: begin
                // R6 R7 R5 data one cycle ahead, then write enable low
                pins_d.addr  = col_of(act_d.addr, cfg_square);
                pins_d.cas_n = 1'b0;
                pins_d.dq_oe = 1'b1;
                pins_d.we_n  = (cnt_d >= `EDOC_CNT_W'(`EDOC_C_CWL));
            end
            edoc_pkg::EDOC_S_RCAS,
            edoc_pkg::EDOC_S_RRAS: begin
                pins_d.cas_n = 1'b0;
                // R10 write enable low around row strobe fall only for test entry
                pins_d.we_n  = !tst_d;
            end
            edoc_pkg::EDOC_S_SELF: begin
                pins_d.cas_n = 1'b0;
            end
            default: begin
                pins_d.addr = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= edoc_pkg::EDOC_S_IDLE;
            cnt_q     <= '0;
            ras_cnt_q <= '0;
            act_q     <= '0;
            cur_q     <= '0;
            cur_vld_q <= 1'b0;
            self_q    <= 1'b0;
            tst_q     <= 1'b0;
            burst_q   <= '0;
            refi_q    <= '0;
            pend_q    <= 1'b0;
            pins_q    <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
            req_ready <= 1'b0;
        end else begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            ras_cnt_q <= ras_cnt_d;
            act_q     <= act_d;
            cur_q     <= cur_d;
            cur_vld_q <= cur_vld_d;
            self_q    <= self_d;
            tst_q     <= tst_d;
            burst_q   <= burst_d;
            refi_q    <= refi_d;
            pend_q    <= pend_d;
            pins_q    <= pins_d;
            req_ready <= !cur_vld_d;
        end
    end

    // R20 sample before the column strobe rises, 40 ns after it falls, so 60 ns after row strobe on a row's first access
    assign buf_push = (state_q == edoc_pkg::EDOC_S_COL) && done && reads(act_q.op);

    edoc_buf #(
        .WIDTH (`EDOC_DQ_W),
        .DEPTH (`EDOC_BUF_DEPTH)
    ) u_rd_buf (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (buf_push),
        .in_ready  (buf_ready),
        .in_data   (dq_in),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    assign pins        = pins_q;
    assign self_active = self_q;

endmodule : edoc_ctrl

/* verif/edoc_properties.sv */
// pin protocol checks for the dram controller
`timescale 1ns/1ps
module edoc_properties (
    input wire logic                 sys_clk,
    input wire logic                 rst_n,
    input wire edoc_pkg::edoc_pins_s pins
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_col_after_row:
        assert property ($fell(pins.cas_n) && !pins.ras_n |-> !$past(pins.ras_n, 2))
        else $error("column strobe too close to row strobe");
    a_we_row_fall:
        assert property ($fell(pins.ras_n) && pins.cas_n |-> pins.we_n && $past(pins.we_n))
        else $error("write enable low at row strobe");
    a_write_oe_high:
        assert property (!pins.we_n && !pins.cas_n |-> pins.oe_n)
        else $error("output gate low during write");
    a_drive_oe_off:
        assert property (pins.dq_oe |-> pins.oe_n)
        else $error("data driven against device output");
    a_wdata_hold:
        assert property (($fell(pins.cas_n) || $fell(pins.we_n)) && !pins.we_n && !pins.cas_n
            && pins.dq_oe |=> pins.dq_oe && $stable(pins.dq_out))
        else $error("write data not held");
    a_test_we_held:
        assert property ($fell(pins.ras_n) && !pins.cas_n |-> $stable(pins.we_n) ##1 $stable(pins.we_n))
        else $error("write enable moved around refresh");
    a_precharge_min:
        assert property ($rose(pins.ras_n) |-> pins.ras_n [*4])
        else $error("row precharge too short");
    a_read_we_high:
        assert property ($fell(pins.cas_n) && !pins.ras_n && !pins.oe_n |-> pins.we_n [*4])
        else $error("read command not held");
endmodule : edoc_properties

bind edoc_ctrl edoc_properties u_props (.sys_clk(sys_clk), .rst_n(rst_n), .pins(pins));

/* verif/edoc_dram_model.sv */
// behavioural extended-output page dram
`timescale 1ns/1ps
module edoc_dram_model (
    input  wire edoc_pkg::edoc_pins_s pins,
    output logic [3:0]               dq_in
);
    logic [3:0]  mem [logic [25:0]];
    logic [12:0] row;
    logic [25:0] key;
    logic [3:0]  rd_val;
    logic        acc = 1'b0;
    logic        rd_on = 1'b0;
    logic [3:0]  last = 4'h0;
    // row first; cas-first is a refresh
    always @(negedge pins.ras_n) begin
        acc = pins.cas_n;
        row = pins.addr;
    end
    // column latch, early write keeps pins open
    always @(negedge pins.cas_n) if (acc && !pins.ras_n) begin
        key = {row, pins.addr};
        rd_val = mem[key];
        rd_on = pins.we_n;
        if (!pins.we_n) mem[key] = pins.dq_out;
    end
    // late data taken at write strobe
    always @(negedge pins.we_n) if (acc && !pins.cas_n) begin
        mem[key] = pins.dq_out;
        rd_on = 1'b0;
    end
    // off once both strobes are up
    always @(posedge pins.cas_n or posedge pins.ras_n)
        if ((pins.ras_n && pins.cas_n) || pins.oe_n) rd_on = 1'b0;
    always @(posedge pins.oe_n) if (pins.cas_n) rd_on = 1'b0;
    // released pins show the inverse, not a stale word
    assign dq_in = (rd_on && !pins.oe_n) ? rd_val : ~last;
    always @(dq_in) if (rd_on && !pins.oe_n) last = dq_in;
endmodule : edoc_dram_model

/* verif/testbench.sv */
// self-checking bench for the dram controller
`timescale 1ns/1ps
module testbench;
    logic sys_clk, self_active, req_ready, rd_valid;
    logic rst_n = 1'b0, self_req = 1'b0, req_valid = 1'b0, rd_ready = 1'b0, test_seen = 1'b0;
    logic cfg_square = 1'b0;
    logic [3:0] rd_data, dq_in;
    edoc_pkg::edoc_req_s req = '0;
    edoc_pkg::edoc_pins_s pins;
    int num_errors = 0, samples_checked = 0, cycles = 0, ref_cnt = 0, n0;
    edoc_ctrl #(.SELF_MIN_CYC(20), .PAGE_MAX_CYC(64)) uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .cfg_square(cfg_square), .self_req(self_req),
        .self_active(self_active), .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .pins(pins), .dq_in(dq_in));
    edoc_dram_model u_mem (.pins(pins), .dq_in(dq_in));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(negedge pins.ras_n) if (!pins.cas_n) begin
        // test-mode entries are not plain refreshes
        ref_cnt += pins.we_n;
        test_seen |= !pins.we_n;
    end
    // ceiling covers the full refresh burst after self refresh
    always @(posedge sys_clk) if (++cycles == 90000) begin
        num_errors++;
        print_verdict();
    end
    task automatic check(input logic [3:0] g, input logic [3:0] e);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check
    task automatic send(input logic [2:0] op, input logic [23:0] a, input logic [3:0] d);
        req_valid <= 1'b1;
        req <= '{edoc_pkg::edoc_op_e'(op), a, d};
        do @(posedge sys_clk); while (req_ready !== 1'b1);
    endtask : send
    task automatic drain(input logic [3:0] e[$]);
        rd_ready <= 1'b1;
        foreach (e[i]) begin
            do @(posedge sys_clk); while (rd_valid !== 1'b1);
            check(rd_data, e[i]);
        end
        rd_ready <= 1'b0;
    endtask : drain
    task automatic t_access();
        send(3'h1, 24'h000010, 4'h5);
        send(3'h1, 24'h000011, 4'hA);
        send(3'h2, 24'h000012, 4'h3);
        send(3'h0, 24'h000011, 4'h0);
        send(3'h3, 24'h000010, 4'hC);
        send(3'h0, 24'h000010, 4'h0);
        req_valid <= 1'b0;
        repeat (40) @(posedge sys_clk);
        check({3'h0, req_ready}, 4'h0);
        drain('{4'hA, 4'h5, 4'hC});
        @(posedge sys_clk);
        check({3'h0, rd_valid}, 4'h0);
    endtask : t_access
    // square split write must land where the narrow split finds row 1 column 0
    task automatic t_square();
        cfg_square <= 1'b1;
        send(3'h1, 24'h001000, 4'h7);
        req_valid <= 1'b0;
        repeat (30) @(posedge sys_clk);
        cfg_square <= 1'b0;
        send(3'h0, 24'h000800, 4'h0);
        req_valid <= 1'b0;
        drain('{4'h7});
    endtask : t_square
    task automatic t_self();
        send(3'h4, 24'h000000, 4'h0);
        req_valid <= 1'b0;
        self_req <= 1'b1;
        do @(posedge sys_clk); while (self_active !== 1'b1);
        repeat (30) @(posedge sys_clk);
        self_req <= 1'b0;
        do @(posedge sys_clk); while (self_active !== 1'b0);
        n0 = ref_cnt;
        send(3'h0, 24'h000012, 4'h0);
        req_valid <= 1'b0;
        drain('{4'h3});
        check({3'h0, test_seen}, 4'h1);
        check({3'h0, (ref_cnt - n0 >= 4096)}, 4'h1);
    endtask : t_self
    task automatic print_verdict();
        if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_access();
        t_square();
        t_self();
        print_verdict();
    end
endmodule : testbench
